/* File: design/lpwc_top.v */
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`include "lpwc_regs.vh"

module lpwc_top (
    // Clock and reset
    input  wire        core_clk_i,
    input  wire        rst_n_i,
    // Avalon-MM slave
    input  wire [7:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    // Wake pins, wake events and crystal ready
    input  wire [4:0]  wake_pin_i,
    input  wire        radio_timer_wake_i,
    input  wire        xo_ready_i,
    // Normal pin controller settings for the first three pins
    input  wire [2:0]  normal_pin_direction_i,
    input  wire [2:0]  normal_pin_out_i,
    input  wire [2:0]  normal_pin_drive_i,
    input  wire [2:0]  normal_pin_pull_i,
    // First three pin drive
    output wire [2:0]  pin_out_o,
    output wire [2:0]  pin_oe_o,
    output wire [2:0]  pin_drive_o,
    output wire [2:0]  pin_pullup_en_o,
    // Clock sources
    output wire        rc16_en_o,
    output wire        xo_en_o,
    output wire        hf_sel_xo_o,
    output wire        lf_osc_en_o,
    output wire        crystal_32mhz_o,
    // Supplies
    output wire        main_supply_en_o,
    output wire        ram_retention_en_o,
    // State
    output wire [1:0]  power_state_o,
    output wire        wake_event_o
);

    // Power states
    localparam [1:0] ST_PREACTIVE = 2'b00;
    localparam [1:0] ST_ACTIVE    = 2'b01;
    localparam [1:0] ST_STANDBY   = 2'b10;
    localparam [1:0] ST_SLEEP     = 2'b11;

    // Standby and sleep are the low-power states
    function lp_state;
        input [1:0] s;
        begin
            lp_state = (s == ST_STANDBY) || (s == ST_SLEEP);
        end
    endfunction

    // Register bank
    reg [4:0]  wake_level_select_q;
    reg [4:0]  wake_pin_enable_q;
    reg        crystal_freq_indicator_q;
    reg [2:0]  lowpower_pin_direction_q;
    reg [2:0]  lowpower_pin_output_q;
    reg [2:0]  lowpower_pin_drive_q;
    reg [2:0]  lowpower_pin_pull_q;

    // Bus slave state
    reg        waitreq_q;
    reg [31:0] rdata_q;

    // Synchronisers
    reg [4:0]  wake_meta_q;
    reg [4:0]  wake_sync_q;
    reg        xo_meta_q;
    reg        xo_sync_q;

    // Power machine
    reg [1:0]  state_q;
    reg [1:0]  state_d;
    reg        xo_start_q;
    reg        xo_start_d;
    reg [2:0]  cmd_q;
    reg        wake_seen_q;

    // Registered outputs
    reg [2:0]  pin_out_q;
    reg [2:0]  pin_oe_q;
    reg [2:0]  pin_drive_q;
    reg [2:0]  pin_pull_q;
    reg        rc16_en_q;
    reg        xo_en_q;
    reg        hf_sel_xo_q;
    reg        lf_osc_en_q;
    reg        main_supply_q;
    reg        ram_ret_q;
    reg        wake_evt_q;

    wire       acc_go;
    wire       wr_go;
    wire       be0;
    wire [4:0] wake_match;
    wire       pin_wake;
    wire       low_power;
    wire       lp_next;
    wire       wake_ret;
    reg [31:0] rmux;

    // Access is taken while waitrequest is high, completes when it is low
    assign acc_go = (avs_read_i | avs_write_i) & waitreq_q;
    assign wr_go  = avs_write_i & ~waitreq_q;
    assign be0    = avs_byteenable_i[0];

    // Wake detection on synchronised pins
    assign wake_match = ~(wake_sync_q ^ wake_level_select_q);
    assign pin_wake   = |(wake_match & wake_pin_enable_q);
    // Low-power decode for the present and the next state
    assign low_power  = lp_state(state_q);
    assign lp_next    = lp_state(state_d);
    // Leaving standby or sleep for preactive marks a wake
    assign wake_ret   = low_power & (state_d == ST_PREACTIVE);

    // Two-stage synchronisers for pins and crystal ready
    // Only the second stage feeds logic, hiding a metastable first stage
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            wake_meta_q <= 5'h00;
            wake_sync_q <= 5'h00;
            xo_meta_q   <= 1'b0;
            xo_sync_q   <= 1'b0;
        end else begin
            wake_meta_q <= wake_pin_i;
            wake_sync_q <= wake_meta_q;
            xo_meta_q   <= xo_ready_i;
            xo_sync_q   <= xo_meta_q;
        end
    end

    // Read data multiplexer, reserved bits and holes read zero
    always @* begin
        rmux = 32'h0000_0000;
        case (avs_address_i)
            `LPWC_OFS_WAKE_LEVEL: rmux[4:0] = wake_level_select_q;
            `LPWC_OFS_WAKE_EN:    rmux[4:0] = wake_pin_enable_q;
            `LPWC_OFS_SYS_CTRL:   rmux[0]   = crystal_freq_indicator_q;
            `LPWC_OFS_LP_DIR:     rmux[2:0] = lowpower_pin_direction_q;
            `LPWC_OFS_LP_OUT:     rmux[2:0] = lowpower_pin_output_q;
            `LPWC_OFS_LP_DRIVE:   rmux[2:0] = lowpower_pin_drive_q;
            `LPWC_OFS_LP_PULL:    rmux[2:0] = lowpower_pin_pull_q;
            // Status word: state, crystal starting, wake seen
            `LPWC_OFS_PWR_STATUS: begin
                rmux[`LPWC_STAT_STATE_LO+1:`LPWC_STAT_STATE_LO] = state_q;
                rmux[`LPWC_STAT_XO_START] = xo_start_q;
                rmux[`LPWC_STAT_WAKE_LO]  = wake_seen_q;
            end
            default:              rmux = 32'h0000_0000;
        endcase
    end

    // Bus handshake: one wait cycle, then one cycle with waitrequest low
    // Read data are taken on the first edge and held until the next access
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            waitreq_q <= 1'b1;
            rdata_q   <= 32'h0000_0000;
        end else if (acc_go) begin
            waitreq_q <= 1'b0;
            rdata_q   <= avs_read_i ? rmux : 32'h0000_0000;
        end else begin
            waitreq_q <= 1'b1;
        end
    end

    // Register writes on the completing edge, byte lane 0 only
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            wake_level_select_q      <= `LPWC_RST_WAKE_LEVEL;
            wake_pin_enable_q        <= `LPWC_RST_WAKE_EN;
            crystal_freq_indicator_q <= `LPWC_RST_SYS_CTRL;
            lowpower_pin_direction_q <= `LPWC_RST_LP_DIR;
            lowpower_pin_output_q    <= `LPWC_RST_LP_OUT;
            lowpower_pin_drive_q     <= `LPWC_RST_LP_DRIVE;
            lowpower_pin_pull_q      <= `LPWC_RST_LP_PULL;
            cmd_q                    <= 3'h0;
        end else begin
            cmd_q <= 3'h0;
            if (wr_go && be0) begin
                case (avs_address_i)
                    // Wake configuration and crystal frequency indicator
                    `LPWC_OFS_WAKE_LEVEL:
                        wake_level_select_q <= avs_writedata_i[4:0];
                    `LPWC_OFS_WAKE_EN:
                        wake_pin_enable_q <= avs_writedata_i[4:0];
                    `LPWC_OFS_SYS_CTRL:
                        crystal_freq_indicator_q <= avs_writedata_i[0];
                    // Low-power pin settings
                    `LPWC_OFS_LP_DIR:
                        lowpower_pin_direction_q <= avs_writedata_i[2:0];
                    `LPWC_OFS_LP_OUT:
                        lowpower_pin_output_q <= avs_writedata_i[2:0];
                    `LPWC_OFS_LP_DRIVE:
                        lowpower_pin_drive_q <= avs_writedata_i[2:0];
                    `LPWC_OFS_LP_PULL:
                        lowpower_pin_pull_q <= avs_writedata_i[2:0];
                    // Power command is a one-cycle pulse
                    `LPWC_OFS_PWR_CMD:
                        cmd_q <= avs_writedata_i[2:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Power state machine
    // Every wake lands in preactive; software reissues the active command
    always @* begin
        state_d    = state_q;
        xo_start_d = xo_start_q;
        case (state_q)
            // Preactive: sleep beats standby beats the crystal start
            ST_PREACTIVE: begin
                if (cmd_q[`LPWC_CMD_SLEEP]) begin
                    state_d    = ST_SLEEP;
                    xo_start_d = 1'b0;
                end else if (cmd_q[`LPWC_CMD_STANDBY]) begin
                    state_d    = ST_STANDBY;
                    xo_start_d = 1'b0;
                end else if (xo_start_q && xo_sync_q) begin
                    state_d    = ST_ACTIVE;
                    xo_start_d = 1'b0;
                end else if (cmd_q[`LPWC_CMD_ACTIVE]) begin
                    xo_start_d = 1'b1;
                end
            end
            // Active: only a low-power command leaves
            ST_ACTIVE: begin
                if (cmd_q[`LPWC_CMD_SLEEP]) begin
                    state_d = ST_SLEEP;
                end else if (cmd_q[`LPWC_CMD_STANDBY]) begin
                    state_d = ST_STANDBY;
                end
            end
            // Standby: enabled pins alone can wake
            ST_STANDBY: begin
                if (pin_wake) begin
                    state_d = ST_PREACTIVE;
                end
            end
            // Sleep: enabled pins or the radio timer wake
            ST_SLEEP: begin
                if (pin_wake || radio_timer_wake_i) begin
                    state_d = ST_PREACTIVE;
                end
            end
            // Any other code falls back to preactive
            default: begin
                state_d    = ST_PREACTIVE;
                xo_start_d = 1'b0;
            end
        endcase
    end

    // State registers and wake record
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_q     <= ST_PREACTIVE;
            xo_start_q  <= 1'b0;
            wake_seen_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            xo_start_q <= xo_start_d;
            // A wake in the same cycle as a clear wins
            if (wake_ret) begin
                wake_seen_q <= 1'b1;
            end else if (wr_go && avs_address_i == `LPWC_OFS_PWR_STATUS
                         && be0 && avs_writedata_i[`LPWC_STAT_WAKE_LO]) begin
                wake_seen_q <= 1'b0;
            end
        end
    end

    // Clock and supply controls per state
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rc16_en_q     <= 1'b1;
            xo_en_q       <= 1'b0;
            hf_sel_xo_q   <= 1'b0;
            lf_osc_en_q   <= 1'b1;
            main_supply_q <= 1'b1;
            ram_ret_q     <= 1'b1;
            wake_evt_q    <= 1'b0;
        end else begin
            // RC fast clock only in preactive
            rc16_en_q     <= (state_d == ST_PREACTIVE);
            // Crystal on while starting and in active
            xo_en_q       <= (state_d == ST_ACTIVE) | xo_start_d;
            hf_sel_xo_q   <= (state_d == ST_ACTIVE);
            // Slow oscillator off only in standby
            lf_osc_en_q   <= (state_d != ST_STANDBY);
            // Main supply only while running
            main_supply_q <= (state_d == ST_PREACTIVE)
                           | (state_d == ST_ACTIVE);
            ram_ret_q     <= 1'b1;
            // One-cycle pulse on each wake
            wake_evt_q    <= wake_ret;
        end
    end

    // Pin control, low-power settings override the normal controller
    // Wake-enabled pins never drive in standby or sleep, so a pin cannot mask its own wake
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pin_out_q   <= 3'h0;
            pin_oe_q    <= 3'h0;
            pin_drive_q <= 3'h0;
            pin_pull_q  <= 3'h7;
        end else if (lp_next) begin
            pin_out_q   <= lowpower_pin_output_q;
            pin_oe_q    <= ~lowpower_pin_direction_q
                         & ~wake_pin_enable_q[2:0];
            pin_drive_q <= lowpower_pin_drive_q;
            pin_pull_q  <= lowpower_pin_pull_q;
        end else begin
            pin_out_q   <= normal_pin_out_i;
            pin_oe_q    <= ~normal_pin_direction_i;
            pin_drive_q <= normal_pin_drive_i;
            pin_pull_q  <= normal_pin_pull_i;
        end
    end

    // Output drive
    // Each output is taken straight from a register
    assign avs_readdata_o     = rdata_q;
    assign avs_waitrequest_o  = waitreq_q;
    assign pin_out_o          = pin_out_q;
    assign pin_oe_o           = pin_oe_q;
    assign pin_drive_o        = pin_drive_q;
    assign pin_pullup_en_o    = pin_pull_q;
    assign rc16_en_o          = rc16_en_q;
    assign xo_en_o            = xo_en_q;
    assign hf_sel_xo_o        = hf_sel_xo_q;
    assign lf_osc_en_o        = lf_osc_en_q;
    assign crystal_32mhz_o    = crystal_freq_indicator_q;
    assign main_supply_en_o   = main_supply_q;
    assign ram_retention_en_o = ram_ret_q;
    assign power_state_o      = state_q;
    assign wake_event_o       = wake_evt_q;

endmodule // lpwc_top

/* File: design/lpwc_regs.vh */
`ifndef LPWC_REGS_VH
`define LPWC_REGS_VH

// Register byte offsets
`define LPWC_OFS_WAKE_LEVEL   8'h00
`define LPWC_OFS_WAKE_EN      8'h04
`define LPWC_OFS_SYS_CTRL     8'h08
`define LPWC_OFS_LP_DIR       8'h0c
`define LPWC_OFS_LP_OUT       8'h10
`define LPWC_OFS_LP_DRIVE     8'h14
`define LPWC_OFS_LP_PULL      8'h18
`define LPWC_OFS_PWR_CMD      8'h1c
`define LPWC_OFS_PWR_STATUS   8'h20

// Field widths
`define LPWC_WAKE_W           5
`define LPWC_LP_W             3

// Reset values
`define LPWC_RST_WAKE_LEVEL   5'h00
`define LPWC_RST_WAKE_EN      5'h07
`define LPWC_RST_SYS_CTRL     1'h0
`define LPWC_RST_LP_DIR       3'h7
`define LPWC_RST_LP_OUT       3'h0
`define LPWC_RST_LP_DRIVE     3'h0
`define LPWC_RST_LP_PULL      3'h0

// Power command bits
`define LPWC_CMD_ACTIVE       0
`define LPWC_CMD_STANDBY      1
`define LPWC_CMD_SLEEP        2

// Power status fields
`define LPWC_STAT_STATE_LO    0
`define LPWC_STAT_XO_START    2
`define LPWC_STAT_WAKE_LO     3

`endif

/* File: verification/lpwc_monitor.sv */
`timescale 1ns/1ps
module lpwc_monitor (
    // Clock and reset
    input wire       core_clk_i,
    input wire       rst_n_i,
    // Bus handshake
    input wire       avs_read_i,
    input wire       avs_write_i,
    input wire       avs_waitrequest_o,
    // Clocks, supplies and state
    input wire       rc16_en_o,
    input wire       xo_en_o,
    input wire       hf_sel_xo_o,
    input wire       lf_osc_en_o,
    input wire       main_supply_en_o,
    input wire       ram_retention_en_o,
    input wire [1:0] power_state_o,
    input wire       wake_event_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Supplies and oscillators follow the power state
    chk_ram_kept: assert property (ram_retention_en_o)
        else $error("retention supply dropped");
    chk_rc_preact: assert property (rc16_en_o == (power_state_o == 2'h0))
        else $error("fast rc enable wrong");
    chk_hf_active: assert property (hf_sel_xo_o == (power_state_o == 2'h1))
        else $error("crystal select wrong");
    chk_lf_osc: assert property (lf_osc_en_o == (power_state_o != 2'h2))
        else $error("slow oscillator enable wrong");
    chk_supply_off: assert property (main_supply_en_o == !power_state_o[1])
        else $error("main supply wrong");
    chk_xo_first: assert property ($rose(hf_sel_xo_o) |-> $past(xo_en_o))
        else $error("crystal selected before start");
    // Leaving a low-power state lands in preactive with crystal off
    chk_wake_pre: assert property ($past(power_state_o[1]) &&
        power_state_o != $past(power_state_o) |->
        power_state_o == 2'h0 && !xo_en_o)
        else $error("wake did not return to preactive");
    chk_wake_pulse: assert property (wake_event_o |=> !wake_event_o)
        else $error("wake pulse too long");
    chk_wake_back: assert property (wake_event_o |->
        power_state_o == 2'h0 && $past(power_state_o[1]))
        else $error("wake pulse without a wake");
    chk_wait_one: assert property ((avs_read_i || avs_write_i) &&
        avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer not one cycle");

    // Main scenarios
    cov_standby: cover property (power_state_o == 2'h2 ##1 power_state_o == 2'h0);
    cov_sleep: cover property (power_state_o == 2'h3 ##1 power_state_o == 2'h0);
    cov_active: cover property ($rose(hf_sel_xo_o));
endmodule // lpwc_monitor

/* File: verification/lpwc_wake_ext.sv */
`timescale 1ns/1ps
module lpwc_wake_ext #(
    parameter XO_DLY = 6
) (
    // Clock and stimulus
    input  wire       core_clk_i,
    input  wire [4:0] drv_en_i,
    input  wire [4:0] drv_val_i,
    input  wire       xo_en_i,
    // Pins and crystal status
    output wire [4:0] wake_pin_o,
    output wire       xo_ready_o
);
    reg [4:0] last_q;
    reg [7:0] cnt_q;
    // Driven pins show the level; released first three sit on the pull-up,
    // released fourth and fifth float, shown as the inverse of the last level
    assign wake_pin_o = (drv_en_i & drv_val_i) |
                        (~drv_en_i & {~last_q[4:3], 3'h7});
    assign xo_ready_o = (cnt_q == XO_DLY);
    // Remember last driven level, count crystal start-up time
    always @(posedge core_clk_i) begin
        last_q <= (drv_en_i & drv_val_i) | (~drv_en_i & last_q);
        if (!xo_en_i)
            cnt_q <= 8'h00;
        else if (cnt_q != XO_DLY)
            cnt_q <= cnt_q + 8'h01;
    end
endmodule // lpwc_wake_ext

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    reg core_clk_i, rst_n_i, rd, wr, radio;
    reg [7:0] addr;
    reg [31:0] wdata, rdata, lfsr;
    reg [3:0] be;
    reg [4:0] den, dval;
    reg [11:0] nrm;
    wire [31:0] rdo;
    wire [4:0] pins;
    wire [2:0] p_out, p_oe, p_drv, p_pull;
    wire [1:0] st;
    wire wrq, xo_rdy, rc16, xo_en, hfsel, lfen, c32, msup, ram, wev;
    integer n_mismatch, tests_run, cyc, i, k;

    lpwc_top u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdo), .avs_waitrequest_o(wrq), .wake_pin_i(pins),
        .radio_timer_wake_i(radio), .xo_ready_i(xo_rdy),
        .normal_pin_direction_i(nrm[2:0]), .normal_pin_out_i(nrm[5:3]),
        .normal_pin_drive_i(nrm[8:6]), .normal_pin_pull_i(nrm[11:9]),
        .pin_out_o(p_out), .pin_oe_o(p_oe), .pin_drive_o(p_drv),
        .pin_pullup_en_o(p_pull), .rc16_en_o(rc16), .xo_en_o(xo_en),
        .hf_sel_xo_o(hfsel), .lf_osc_en_o(lfen), .crystal_32mhz_o(c32),
        .main_supply_en_o(msup), .ram_retention_en_o(ram),
        .power_state_o(st), .wake_event_o(wev));
    lpwc_wake_ext u_ext (.core_clk_i(core_clk_i), .drv_en_i(den),
        .drv_val_i(dval), .xo_en_i(xo_en), .wake_pin_o(pins),
        .xo_ready_o(xo_rdy));

    function [31:0] lfsr_next(input [31:0] v);
        lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Implemented bits per register index
    function [31:0] msk(input integer r);
        msk = (r < 2) ? 32'h1f : (r == 2) ? 32'h01 : 32'h07;
    endfunction

    task check(input [31:0] got, input [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low
    task bus(input w, input [7:0] a, input [31:0] d);
        @(posedge core_clk_i);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge core_clk_i);
        while (wrq !== 1'b0) @(posedge core_clk_i);
        rdata = rdo;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task wait_st(input [1:0] s);
        integer j;
        j = 0;
        while (st !== s && j < 100) begin
            @(posedge core_clk_i);
            j = j + 1;
        end
        check(st, s);
    endtask
    task give_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Clock and hang guard
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            give_verdict;
        end
    end

    // Main sequence
    initial begin
        n_mismatch = 0; tests_run = 0; cyc = 0; lfsr = 32'h4;
        rst_n_i = 1'b0; rd = 1'b0; wr = 1'b0; radio = 1'b0; addr = 8'h00;
        wdata = 32'h0; be = 4'hf; den = 5'h1f; dval = 5'h1f; nrm = 12'h000;
        repeat (6) @(posedge core_clk_i);
        check(p_pull, 3'h7);
        rst_n_i <= 1'b1;
        check(st, 2'h0);
        check(lfen, 1'b1);
        for (k = 0; k < 8; k = k + 1) begin
            bus(1'b0, k * 4, 32'h0);
            check(rdata, (k == 1 || k == 3) ? 32'h7 : 32'h0);
        end
        bus(1'b0, 8'h40, 32'h0);
        check(rdata, 32'h0);
        // Random write and read back, normal pin pass-through
        for (i = 0; i < 24; i = i + 1) begin
            lfsr = lfsr_next(lfsr);
            k = lfsr[10:8] % 7;
            nrm <= lfsr[23:12];
            bus(1'b1, k * 4, lfsr);
            bus(1'b0, k * 4, 32'h0);
            check(rdata, lfsr & msk(k));
            check({p_pull, p_out, p_oe}, {nrm[11:9], nrm[5:3], ~nrm[2:0]});
            check(p_drv, nrm[8:6]);
        end
        bus(1'b1, 8'h04, 32'h9);
        be <= 4'h0;
        bus(1'b1, 8'h04, 32'h0);
        be <= 4'hf;
        bus(1'b1, 8'h40, 32'hffffffff);
        bus(1'b0, 8'h04, 32'h0);
        check(rdata, 32'h9);
        // Crystal indication and active state
        bus(1'b1, 8'h08, 32'h1);
        bus(1'b1, 8'h1c, 32'h1);
        wait_st(2'h1);
        check({hfsel, rc16, xo_en, c32}, 4'b1011);
        // Standby: pin0 and pin3 wake high, pin0 also set as lp output
        dval <= 5'h16;
        den <= 5'h19;
        bus(1'b1, 8'h00, 32'h9);
        bus(1'b1, 8'h0c, 32'h0);
        bus(1'b1, 8'h10, 32'h5);
        bus(1'b1, 8'h14, 32'h3);
        bus(1'b1, 8'h18, 32'h6);
        bus(1'b1, 8'h1c, 32'h2);
        wait_st(2'h2);
        check({msup, lfen, ram}, 3'b001);
        check({p_oe, p_out, p_drv, p_pull}, 12'hd5e);
        radio <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        radio <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        check(st, 2'h2);
        dval <= 5'h1e;
        wait_st(2'h0);
        check(wev, 1'b1);
        check(xo_en, 1'b0);
        bus(1'b0, 8'h20, 32'h0);
        check(rdata, 32'h8);
        bus(1'b1, 8'h20, 32'h8);
        bus(1'b0, 8'h20, 32'h0);
        check(rdata, 32'h0);
        // Sleep, woken by the radio timer
        dval <= 5'h16;
        bus(1'b1, 8'h1c, 32'h4);
        wait_st(2'h3);
        check({lfen, msup}, 2'b10);
        radio <= 1'b1;
        @(posedge core_clk_i);
        radio <= 1'b0;
        wait_st(2'h0);
        check(wev, 1'b1);
        bus(1'b0, 8'h20, 32'h0);
        check(rdata, 32'h8);
        give_verdict;
    end
endmodule // tb_top

bind lpwc_top lpwc_monitor u_mon (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o), .rc16_en_o(rc16_en_o),
    .xo_en_o(xo_en_o), .hf_sel_xo_o(hf_sel_xo_o), .lf_osc_en_o(lf_osc_en_o),
    .main_supply_en_o(main_supply_en_o),
    .ram_retention_en_o(ram_retention_en_o), .power_state_o(power_state_o),
    .wake_event_o(wake_event_o));
